/* design/gpio_pkg.sv */
// Purpose: Shared constants for the dual port GPIO with change detection.
// Assumes: AHB-Lite register access, 32-bit words, one register per word.
// Notes: Register indices are word indices; the byte address is four times the index.
package gpio_pkg;
    // Register indices (byte address = index * 4)
    localparam logic [7:0] IDX_SECOND_PORT_DATA = 8'h06;
    localparam logic [7:0] IDX_THIRD_PORT_PIN_DATA = 8'h07;
    localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0B;
    localparam logic [7:0] IDX_OPTION = 8'h81;
    localparam logic [7:0] IDX_SECOND_PORT_DIRECTION = 8'h86;
    localparam logic [7:0] IDX_THIRD_PORT_DIRECTION = 8'h87;
    // Field positions
    localparam int PULLUP_DISABLE_N_BIT = 7;
    localparam int PORT_CHANGE_FLAG_BIT = 0;
    localparam int PORT_CHANGE_ENABLE_BIT = 3;
    localparam int MONITOR_LO = 4;
    localparam int MONITOR_HI = 7;
    // Values after reset
    localparam logic [7:0] DIRECTION_RESET = 8'hFF;
    localparam logic [7:0] OPTION_RESET = 8'hFF;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;
endpackage : gpio_pkg

/* design/dual_port_gpio_change_detect.sv */
// Purpose: Two 8-bit bidirectional ports, pull-ups and upper-pin change detection on AHB-Lite.
// Assumes: Pins are asynchronous and pass two flip-flops; hclk is 50 MHz.
// Notes: Zero wait states; reads sample pins in the address phase, writes land after the data phase.
// Function
// - Second port: direction 1 tri-states the pin, 0 drives it from the latch.
// - Third port: direction 1 tri-states the pin, 0 drives it from the latch.
// - Second port data read returns pins; a write updates the latch and reloads the change reference.
// - Third port data read returns pins; a write loads the latch only.
// - Port writes read the pins, merge the change, store into the latch.
// - Clearing option bit 7 turns on together the pull-ups of all second-port pins that are inputs.
// - A pull-up is forced off while its pin is an output.
// - Pull-ups are off after power-on reset.
// - Change detection watches only the upper four pins that are inputs.
// - Each watched pin is compared with its value at the last port read or write.
// - Mismatches are ORed and set the change flag at interrupt control bit 0.
// - A pending change flag can wake the device from sleep.
// - A port read or write ends the mismatch; software then clears the flag.
// - A persisting mismatch keeps setting the flag; setting beats clearing.
// - A change coinciding with the port read still sets the flag.
// - The second port is eight bits wide with one direction bit per pin.
// - Writes take effect at cycle end; reads sample pins at cycle start.
`timescale 1ns/1ns
module dual_port_gpio_change_detect #(
    parameter int PORT_WIDTH = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [PORT_WIDTH-1:0] second_pin_in,
    output logic [PORT_WIDTH-1:0] second_pin_out,
    output logic [PORT_WIDTH-1:0] second_pin_oe,
    output logic [PORT_WIDTH-1:0] second_pullup_en,
    input wire logic [PORT_WIDTH-1:0] third_pin_in,
    output logic [PORT_WIDTH-1:0] third_pin_out,
    output logic [PORT_WIDTH-1:0] third_pin_oe,
    output logic wake_req
);

    typedef struct packed {
        logic [PORT_WIDTH-1:0] second_sync1;
        logic [PORT_WIDTH-1:0] second_sync2;
        logic [PORT_WIDTH-1:0] third_sync1;
        logic [PORT_WIDTH-1:0] third_sync2;
        logic [PORT_WIDTH-1:0] second_latch;
        logic [PORT_WIDTH-1:0] second_dir;
        logic [PORT_WIDTH-1:0] third_latch;
        logic [PORT_WIDTH-1:0] third_dir;
        logic [7:0] option;
        logic [3:0] change_ref;
        logic change_flag;
        logic change_enable;
        logic wr_pend;
        logic [7:0] wr_idx;
        logic [31:0] rdata;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // Read-modify-write: unmasked bits take the sampled pin level, masked bits the new data.
    // A zero mask in hwdata[15:8] means a whole-port write.
    function automatic logic [PORT_WIDTH-1:0] rmw_merge(
        input logic [PORT_WIDTH-1:0] pins,
        input logic [31:0] wdata
    );
        logic [PORT_WIDTH-1:0] mask;
        mask = (wdata[15:8] == 8'h00) ? {PORT_WIDTH{1'b1}} : wdata[8 +: PORT_WIDTH];
        rmw_merge = (pins & ~mask) | (wdata[PORT_WIDTH-1:0] & mask);
    endfunction : rmw_merge

    function automatic logic [31:0] widen(input logic [PORT_WIDTH-1:0] v);
        widen = {{(32-PORT_WIDTH){1'b0}}, v};
    endfunction : widen

    logic accept;
    logic [7:0] addr_idx;
    logic [3:0] watched;
    logic mismatch;
    logic port_read;
    logic port_write;
    logic flag_clear;

    assign accept = hsel && hready && (htrans == gpio_pkg::HTRANS_NONSEQ);
    assign addr_idx = haddr[9:2];
    assign port_read = accept && !hwrite && (addr_idx == gpio_pkg::IDX_SECOND_PORT_DATA);
    assign port_write = st_r.wr_pend && (st_r.wr_idx == gpio_pkg::IDX_SECOND_PORT_DATA);
    assign flag_clear = st_r.wr_pend && (st_r.wr_idx == gpio_pkg::IDX_INTERRUPT_CONTROL)
        && !hwdata[gpio_pkg::PORT_CHANGE_FLAG_BIT];

    // Only upper pins that are inputs take part in the comparison
    assign watched = st_r.second_dir[gpio_pkg::MONITOR_HI:gpio_pkg::MONITOR_LO];
    assign mismatch = |((st_r.second_sync2[gpio_pkg::MONITOR_HI:gpio_pkg::MONITOR_LO]
        ^ st_r.change_ref) & watched);

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.second_sync1 = second_pin_in;
        st_nxt.second_sync2 = st_r.second_sync1;
        st_nxt.third_sync1 = third_pin_in;
        st_nxt.third_sync2 = st_r.third_sync1;
        st_nxt.wr_pend = accept && hwrite;
        st_nxt.wr_idx = addr_idx;

        // Data phase of a write: the store lands at the end of the cycle
        if (st_r.wr_pend)
        begin
            case (st_r.wr_idx)
                gpio_pkg::IDX_SECOND_PORT_DATA:
                begin
                    st_nxt.second_latch = rmw_merge(st_r.second_sync2, hwdata);
                end
                gpio_pkg::IDX_THIRD_PORT_PIN_DATA:
                begin
                    st_nxt.third_latch = rmw_merge(st_r.third_sync2, hwdata);
                end
                gpio_pkg::IDX_SECOND_PORT_DIRECTION:
                begin
                    st_nxt.second_dir = hwdata[PORT_WIDTH-1:0];
                end
                gpio_pkg::IDX_THIRD_PORT_DIRECTION:
                begin
                    st_nxt.third_dir = hwdata[PORT_WIDTH-1:0];
                end
                gpio_pkg::IDX_OPTION:
                begin
                    st_nxt.option = hwdata[7:0];
                end
                gpio_pkg::IDX_INTERRUPT_CONTROL:
                begin
                    st_nxt.change_enable = hwdata[gpio_pkg::PORT_CHANGE_ENABLE_BIT];
                end
                default:
                begin
                    st_nxt.wr_pend = accept && hwrite;
                end
            endcase
        end

        // A read or write of the second port reloads the reference and so ends the mismatch.
        // The read samples in the address phase; a pin that moves in that same cycle still
        // mismatches the old reference, so its change is flagged as the reference reloads.
        if (port_read || port_write)
        begin
            st_nxt.change_ref = st_r.second_sync2[gpio_pkg::MONITOR_HI:gpio_pkg::MONITOR_LO];
        end

        // Set wins over the software clear, so the flag only clears once the mismatch ended
        if (mismatch)
        begin
            st_nxt.change_flag = 1'b1;
        end
        else if (flag_clear)
        begin
            st_nxt.change_flag = 1'b0;
        end

        // Read data is taken in the address phase, so pins are sampled at cycle start
        st_nxt.rdata = 32'h0000_0000;
        if (accept && !hwrite)
        begin
            case (addr_idx)
                gpio_pkg::IDX_SECOND_PORT_DATA: st_nxt.rdata = widen(st_r.second_sync2);
                gpio_pkg::IDX_THIRD_PORT_PIN_DATA: st_nxt.rdata = widen(st_r.third_sync2);
                gpio_pkg::IDX_SECOND_PORT_DIRECTION: st_nxt.rdata = widen(st_r.second_dir);
                gpio_pkg::IDX_THIRD_PORT_DIRECTION: st_nxt.rdata = widen(st_r.third_dir);
                gpio_pkg::IDX_OPTION: st_nxt.rdata = {24'h00_0000, st_r.option};
                gpio_pkg::IDX_INTERRUPT_CONTROL:
                begin
                    st_nxt.rdata[gpio_pkg::PORT_CHANGE_FLAG_BIT] = st_r.change_flag;
                    st_nxt.rdata[gpio_pkg::PORT_CHANGE_ENABLE_BIT] = st_r.change_enable;
                end
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_r.second_sync1 <= '0;
            st_r.second_sync2 <= '0;
            st_r.third_sync1 <= '0;
            st_r.third_sync2 <= '0;
            st_r.second_latch <= gpio_pkg::LATCH_RESET;
            st_r.second_dir <= gpio_pkg::DIRECTION_RESET;
            st_r.third_latch <= gpio_pkg::LATCH_RESET;
            st_r.third_dir <= gpio_pkg::DIRECTION_RESET;
            st_r.option <= gpio_pkg::OPTION_RESET;
            st_r.change_ref <= 4'h0;
            st_r.change_flag <= 1'b0;
            st_r.change_enable <= 1'b0;
            st_r.wr_pend <= 1'b0;
            st_r.wr_idx <= 8'h00;
            st_r.rdata <= 32'h0000_0000;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign hrdata = st_r.rdata;
    assign hreadyout = 1'b1;
    assign hresp = gpio_pkg::HRESP_OKAY;

    assign second_pin_out = st_r.second_latch;
    assign second_pin_oe = ~st_r.second_dir;
    assign third_pin_out = st_r.third_latch;
    assign third_pin_oe = ~st_r.third_dir;
    // Active-low enable; outputs never see a pull-up
    assign second_pullup_en = {PORT_WIDTH{~st_r.option[gpio_pkg::PULLUP_DISABLE_N_BIT]}}
        & st_r.second_dir;
    // Level request; the sleep controller decides whether it is asleep
    assign wake_req = st_r.change_flag && st_r.change_enable;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    dir_second_drive_a: assert property (st_r.wr_pend
        && st_r.wr_idx == gpio_pkg::IDX_SECOND_PORT_DIRECTION
        |=> second_pin_oe == ~$past(hwdata[PORT_WIDTH-1:0]))
        else $error("second port enable does not follow direction write");

    dir_third_drive_a: assert property (st_r.wr_pend
        && st_r.wr_idx == gpio_pkg::IDX_THIRD_PORT_DIRECTION
        |=> third_pin_oe == ~$past(hwdata[PORT_WIDTH-1:0]))
        else $error("third port enable does not follow direction write");

    read_pins_a: assert property (port_read
        |=> hrdata[PORT_WIDTH-1:0] == $past(st_r.second_sync2))
        else $error("second port read did not return pin levels");

    rmw_store_a: assert property (port_write
        |=> second_pin_out == rmw_merge($past(st_r.second_sync2), $past(hwdata)))
        else $error("second port write did not merge with pins");

    pullup_gate_a: assert property (second_pullup_en
        == ({PORT_WIDTH{~st_r.option[gpio_pkg::PULLUP_DISABLE_N_BIT]}} & ~second_pin_oe))
        else $error("pull-up on while output or disabled");

    mismatch_sets_a: assert property (mismatch |=> st_r.change_flag)
        else $error("mismatch did not set change flag");

    flag_holds_a: assert property (st_r.change_flag && !flag_clear
        |=> st_r.change_flag)
        else $error("change flag dropped without software clear");

    read_reference_a: assert property (port_read
        |=> st_r.change_ref == $past(st_r.second_sync2[7:4]))
        else $error("reference not captured at port read");

    // Any control write may drop the flag or the enable, so it may end the request
    wake_follows_a: assert property (st_r.change_flag && st_r.change_enable
        |-> wake_req ##1 (wake_req
        || $past(st_r.wr_pend && st_r.wr_idx == gpio_pkg::IDX_INTERRUPT_CONTROL)))
        else $error("pending change did not request wake");

    third_read_pins_a: assert property (accept && !hwrite
        && addr_idx == gpio_pkg::IDX_THIRD_PORT_PIN_DATA
        |=> hrdata[PORT_WIDTH-1:0] == $past(st_r.third_sync2))
        else $error("third port read did not return pin levels");

    third_latch_load_a: assert property (st_r.wr_pend
        && st_r.wr_idx == gpio_pkg::IDX_THIRD_PORT_PIN_DATA && hwdata[15:8] == 8'h00
        |=> third_pin_out == $past(hwdata[PORT_WIDTH-1:0]))
        else $error("third port whole write did not load the latch");

    second_latch_load_a: assert property (port_write
        && hwdata[15:8] == 8'h00
        |=> second_pin_out == $past(hwdata[PORT_WIDTH-1:0]))
        else $error("second port whole write did not load the latch");

    write_keeps_dir_a: assert property (port_write
        |=> $stable(second_pin_oe))
        else $error("second port data write moved the direction");

    second_out_hold_a: assert property (!port_write
        |=> $stable(second_pin_out))
        else $error("second port latch changed without a data write");

    read_keeps_latch_a: assert property (port_read && !st_r.wr_pend
        |=> $stable(second_pin_out))
        else $error("second port read changed the latch");

    third_out_hold_a: assert property (!(st_r.wr_pend
        && st_r.wr_idx == gpio_pkg::IDX_THIRD_PORT_PIN_DATA)
        |=> $stable(third_pin_out))
        else $error("third port latch changed without a data write");

    second_oe_hold_a: assert property (!(st_r.wr_pend
        && st_r.wr_idx == gpio_pkg::IDX_SECOND_PORT_DIRECTION)
        |=> $stable(second_pin_oe))
        else $error("second port enable changed without a direction write");

    third_oe_hold_a: assert property (!(st_r.wr_pend
        && st_r.wr_idx == gpio_pkg::IDX_THIRD_PORT_DIRECTION)
        |=> $stable(third_pin_oe))
        else $error("third port enable changed without a direction write");

    pullup_output_off_a: assert property (
        (second_pullup_en & second_pin_oe) == '0)
        else $error("pull-up on while the pin drives");

    pullup_disabled_a: assert property (st_r.option[gpio_pkg::PULLUP_DISABLE_N_BIT]
        |-> second_pullup_en == '0)
        else $error("pull-up on while disabled");

    pullup_all_on_a: assert property (!st_r.option[gpio_pkg::PULLUP_DISABLE_N_BIT]
        && second_pin_oe == '0
        |-> second_pullup_en == '1)
        else $error("pull-ups did not switch on together");

    write_reference_a: assert property (port_write
        |=> st_r.change_ref == $past(st_r.second_sync2[gpio_pkg::MONITOR_HI:gpio_pkg::MONITOR_LO]))
        else $error("reference not captured at port write");

    flag_clears_a: assert property (flag_clear && !mismatch
        |=> !st_r.change_flag)
        else $error("software clear did not clear the change flag");

    flag_needs_mismatch_a: assert property (!st_r.change_flag && !mismatch
        |=> !st_r.change_flag)
        else $error("change flag set without a mismatch");

    wake_quiet_a: assert property (!st_r.change_flag
        |-> !wake_req)
        else $error("wake requested with no pending change");

    rdata_one_cycle_a: assert property (!(accept && !hwrite)
        |=> hrdata == 32'h0000_0000)
        else $error("read data stood longer than one cycle");

    outputs_unwatched_a: assert property (
        st_r.second_dir[gpio_pkg::MONITOR_HI:gpio_pkg::MONITOR_LO] == 4'h0 |-> !mismatch)
        else $error("output pins took part in change detection");

endmodule : dual_port_gpio_change_detect

/* tb/pin_model.sv */
// Purpose: External side of one 8-bit port: pin driver, pull-up and outside source.
// Assumes: The port's own driver wins over an outside source, which wins over a pull-up.
// Notes: An undriven pin toggles each cycle, so it never reads as a steady level.
`timescale 1ns/1ns
module pin_model (
    input wire logic clk,
    input wire logic [7:0] drv_out,
    input wire logic [7:0] drv_oe,
    input wire logic [7:0] pull_en,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] level
);
    logic [7:0] float_r = 8'h55;
    always @(posedge clk)
    begin
        float_r <= ~level;
    end
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (drv_oe[i])
                level[i] = drv_out[i];
            else if (ext_en[i])
                level[i] = ext_val[i];
            else
                level[i] = pull_en[i] ? 1'b1 : float_r[i];
        end
    end
endmodule : pin_model

/* tb/dual_port_gpio_change_detect_bench.sv */
// Purpose: Self-checking bench for the dual port GPIO with change detection.
// Assumes: Single AHB-Lite slave, zero wait states, hclk 50 MHz.
// Notes: Read results are queued by the driver and compared by a monitor.
`timescale 1ns/1ns
module dual_port_gpio_change_detect_bench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic rd_dph = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, wake_req;
    logic [7:0] b_in, b_out, b_oe, b_pu, c_in, c_out, c_oe, d, v, e;
    logic [7:0] b_ext = 8'h00, b_en = 8'hFF, c_ext = 8'h00, c_en = 8'hFF;
    logic [31:0] exp_q[$];
    int error_cnt = 0;
    int samples_checked = 0;
    always #10 hclk = ~hclk;
    dual_port_gpio_change_detect dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .second_pin_in(b_in), .second_pin_out(b_out), .second_pin_oe(b_oe),
        .second_pullup_en(b_pu), .third_pin_in(c_in), .third_pin_out(c_out),
        .third_pin_oe(c_oe), .wake_req(wake_req));
    pin_model pins_b (.clk(hclk), .drv_out(b_out), .drv_oe(b_oe), .pull_en(b_pu),
        .ext_val(b_ext), .ext_en(b_en), .level(b_in));
    pin_model pins_c (.clk(hclk), .drv_out(c_out), .drv_oe(c_oe), .pull_en(8'h00),
        .ext_val(c_ext), .ext_en(c_en), .level(c_in));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] expv);
        samples_checked++;
        if (seen !== expv)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, expv, seen);
        end
    endtask : chk
    task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= gpio_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : bus
    task automatic rd(input logic [7:0] idx, input logic [31:0] expv);
        exp_q.push_back(expv);
        bus(idx, 1'b0, 32'h0);
    endtask : rd
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    // Data phase value is taken before this edge's updates land
    always @(posedge hclk)
    begin
        if (rd_dph && exp_q.size() > 0)
            chk("hrdata", hrdata, exp_q.pop_front());
        rd_dph <= hsel && htrans == gpio_pkg::HTRANS_NONSEQ && !hwrite;
    end
    initial
    begin
        repeat (3000) @(posedge hclk);
        error_cnt++;
        wrap_up();
    end
    initial
    begin
        void'($urandom(32'hA13D));
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rd(gpio_pkg::IDX_SECOND_PORT_DIRECTION, 32'hFF);
        rd(gpio_pkg::IDX_THIRD_PORT_DIRECTION, 32'hFF);
        rd(gpio_pkg::IDX_OPTION, 32'hFF);
        rd(gpio_pkg::IDX_INTERRUPT_CONTROL, 32'h0);
        rd(8'h3F, 32'h0);
        chk("pullup", b_pu, 32'h0);
        chk("ready_resp", {hreadyout, hresp}, 32'h2);
        $display("test reset done");
        repeat (4)
        begin
            d = 8'($urandom);
            v = 8'($urandom);
            e = 8'($urandom);
            b_ext <= e;
            c_ext <= ~e;
            bus(gpio_pkg::IDX_SECOND_PORT_DIRECTION, 1'b1, {24'h0, d});
            bus(gpio_pkg::IDX_THIRD_PORT_DIRECTION, 1'b1, {24'h0, ~d});
            bus(gpio_pkg::IDX_SECOND_PORT_DATA, 1'b1, {24'h0, v});
            bus(gpio_pkg::IDX_THIRD_PORT_PIN_DATA, 1'b1, {24'h0, ~v});
            repeat (3) @(posedge hclk);
            chk("second_oe", b_oe, {24'h0, ~d});
            chk("third_oe", c_oe, d);
            chk("second_out", b_out, v);
            chk("third_out", c_out, {24'h0, ~v});
            rd(gpio_pkg::IDX_SECOND_PORT_DATA, {24'h0, (v & ~d) | (e & d)});
            rd(gpio_pkg::IDX_THIRD_PORT_PIN_DATA, {24'h0, (~v & d) | (~e & ~d)});
        end
        $display("test direction and data done");
        bus(gpio_pkg::IDX_SECOND_PORT_DIRECTION, 1'b1, 32'hF0);
        repeat (3) @(posedge hclk);
        bus(gpio_pkg::IDX_SECOND_PORT_DATA, 1'b1, 32'h0FA5);
        // The latch lands at the closing edge of the data phase
        @(posedge hclk);
        chk("rmw_out", b_out, {24'h0, e[7:4], 4'h5});
        $display("test masked write done");
        b_en <= 8'h00;
        bus(gpio_pkg::IDX_OPTION, 1'b1, 32'h7F);
        repeat (3) @(posedge hclk);
        chk("pullup", b_pu, 32'hF0);
        rd(gpio_pkg::IDX_SECOND_PORT_DATA, 32'hF5);
        b_en <= 8'hFF;
        b_ext <= 8'h00;
        bus(gpio_pkg::IDX_OPTION, 1'b1, 32'hFF);
        @(posedge hclk);
        chk("pullup", b_pu, 32'h0);
        $display("test pull-ups done");
        bus(gpio_pkg::IDX_SECOND_PORT_DATA, 1'b1, 32'hFF);
        bus(gpio_pkg::IDX_SECOND_PORT_DIRECTION, 1'b1, 32'hFF);
        repeat (3) @(posedge hclk);
        rd(gpio_pkg::IDX_SECOND_PORT_DATA, 32'h00);
        bus(gpio_pkg::IDX_INTERRUPT_CONTROL, 1'b1, 32'h08);
        // Bit 7 turns output and drives 1, low pins move: none may flag
        bus(gpio_pkg::IDX_SECOND_PORT_DIRECTION, 1'b1, 32'h7F);
        b_ext <= 8'h0F;
        repeat (4) @(posedge hclk);
        rd(gpio_pkg::IDX_INTERRUPT_CONTROL, 32'h08);
        chk("wake", wake_req, 32'h0);
        b_ext <= 8'h4F;
        // Waits instead of polling the port, which would reload the reference
        repeat (4) @(posedge hclk);
        chk("wake", wake_req, 32'h1);
        bus(gpio_pkg::IDX_INTERRUPT_CONTROL, 1'b1, 32'h08);
        rd(gpio_pkg::IDX_INTERRUPT_CONTROL, 32'h09);
        rd(gpio_pkg::IDX_SECOND_PORT_DATA, 32'hCF);
        rd(gpio_pkg::IDX_INTERRUPT_CONTROL, 32'h09);
        bus(gpio_pkg::IDX_INTERRUPT_CONTROL, 1'b1, 32'h08);
        rd(gpio_pkg::IDX_INTERRUPT_CONTROL, 32'h08);
        $display("test change detect done");
        wrap_up();
    end
endmodule : dual_port_gpio_change_detect_bench
